// ---- core/pbclk_pkg.sv ----
// Constants and carrier types for the port B clock and transmitter control registers.
// Assumes a single 100 MHz system clock and a register port decoded by the host serial interface.
`default_nettype none

package pbclk_pkg;

	// ==========================================================================
	// Register offsets and reset values
	localparam logic [7:0] PBCLK_OFS_PORT_B_CONTROL_2    = 8'h06;
	localparam logic [7:0] PBCLK_OFS_TRANSMITTER_CTRL_1  = 8'h07;
	localparam logic [3:0] PBCLK_RST_PORT_B_CONTROL_2    = 4'h0;
	localparam logic [7:0] PBCLK_RST_TRANSMITTER_CTRL_1  = 8'h00;
	localparam logic [3:0] PBCLK_PORT_B_CONTROL_2_UPPER  = 4'h0;

	// ==========================================================================
	// Field positions
	localparam int PBCLK_POS_FRAME_DIVIDER   = 0;
	localparam int PBCLK_POS_MASTER_SOURCE   = 2;
	localparam int PBCLK_POS_SLIP_SELECT     = 0;
	localparam int PBCLK_POS_VALIDITY        = 1;
	localparam int PBCLK_POS_BLOCK_START_DIR = 2;
	localparam int PBCLK_POS_INPUT_SOURCE    = 3;
	localparam int PBCLK_POS_TX_DIVIDER      = 5;
	localparam int PBCLK_POS_TX_CLOCK_SOURCE = 7;

	// ==========================================================================
	// Master clock source codes
	localparam logic [1:0] PBCLK_SRC_MAIN_REF     = 2'h0;
	localparam logic [1:0] PBCLK_SRC_RECEIVER_REF = 2'h1;
	localparam logic [1:0] PBCLK_SRC_RECOVERED    = 2'h2;
	localparam logic [1:0] PBCLK_SRC_RESERVED     = 2'h3;

	// ==========================================================================
	// Divider figures: frame period is 128 master clocks times (code + 1).
	localparam int         PBCLK_DIV_BASE          = 128;
	localparam int         PBCLK_BCK_PER_LRCK      = 64;
	localparam logic [5:0] PBCLK_LAST_BIT_TOGGLE   = 6'h3f;
	localparam int         PBCLK_NUM_MASTER_CLOCKS = 3;

	// ==========================================================================
	// Carrier types
	typedef struct packed
	{
		logic [1:0] master_source;
		logic [1:0] port_b_frame_divider;
	} pbclk_port_b_cfg_s;

	// Bit order equals the transmitter control register 1 layout.
	typedef struct packed
	{
		logic       transmitter_clock_source;
		logic [1:0] transmitter_clock_divider;
		logic [1:0] transmitter_input_source;
		logic       block_start_pin_direction;
		logic       validity;
		logic       slip_or_block_start_select;
	} pbclk_tx_cfg_s;

endpackage

`default_nettype wire

// ---- core/pbclk_div.sv ----
// Frame and bit clock generator for port B master mode.
// Assumes tick_i is a one-cycle pulse per rising edge of the selected master clock.
`timescale 1ns/1ps
`default_nettype none

module pbclk_div
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       en_i,
	input  wire logic       restart_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] div_i,
	// Generated clocks
	output var  logic       bit_clk_o,
	output var  logic       frame_clk_o
);

	// ==========================================================================
	// Divider chain
	logic [1:0] half_cnt;
	logic [5:0] tog_cnt;
	logic       next_bit;
	logic       next_frame;
	logic [1:0] next_half_cnt;
	logic [5:0] next_tog_cnt;

	// The divider code equals the last index of master ticks per bit clock half period.
	always_comb
	begin
		next_half_cnt = half_cnt;
		next_tog_cnt  = tog_cnt;
		next_bit      = bit_clk_o;
		next_frame    = frame_clk_o;
		if (!en_i || restart_i)
		begin
			next_half_cnt = 2'h0;
			next_tog_cnt  = 6'h00;
			next_bit      = 1'b0;
			next_frame    = 1'b0;
		end
		else if (tick_i)
		begin
			if (half_cnt >= div_i)
			begin
				next_half_cnt = 2'h0;
				next_bit      = ~bit_clk_o;
				next_tog_cnt  = tog_cnt + 6'h01;
				if (tog_cnt == pbclk_pkg::PBCLK_LAST_BIT_TOGGLE)
				begin
					next_frame = ~frame_clk_o;
				end
			end
			else
			begin
				next_half_cnt = half_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			half_cnt    <= 2'h0;
			tog_cnt     <= 6'h00;
			bit_clk_o   <= 1'b0;
			frame_clk_o <= 1'b0;
		end
		else
		begin
			half_cnt    <= next_half_cnt;
			tog_cnt     <= next_tog_cnt;
			bit_clk_o   <= next_bit;
			frame_clk_o <= next_frame;
		end
	end

	// ==========================================================================
	// Checks on the generated ratios
	logic       armed;
	logic [8:0] tick_seen;
	logic [5:0] bit_chg;
	logic       frame_tog;

	assign frame_tog = (next_frame != frame_clk_o) && en_i && !restart_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !en_i || restart_i)
		begin
			armed     <= 1'b0;
			tick_seen <= 9'h000;
			bit_chg   <= 6'h00;
		end
		else if (tick_i)
		begin
			armed     <= armed | frame_tog;
			tick_seen <= frame_tog ? 9'h000 : tick_seen + 9'h001;
			bit_chg   <= frame_tog ? 6'h00 : bit_chg + 6'((next_bit != bit_clk_o) ? 1 : 0);
		end
	end

	a_frame_div_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_i && frame_tog && armed) |->
		(int'(tick_seen) == (pbclk_pkg::PBCLK_DIV_BASE / 2) * (int'(div_i) + 1) - 1))
		else $error("Frame clock half period does not match the divider code.");

	a_bit_per_frame: assert property (@(posedge clk_i) disable iff (rst_i)
		(frame_tog && armed) |->
		(int'(bit_chg) == pbclk_pkg::PBCLK_BCK_PER_LRCK - 1) && (next_bit != bit_clk_o)
		##1 $fell(bit_clk_o))
		else $error("Bit clock is not 64 times the frame clock.");

endmodule

`default_nettype wire

// ---- core/pbclk_regs.sv ----
// Port B control register 2 and transmitter control register 1 with port B master clock generation.
// Assumes register strobes and the mode, validity and slip inputs come from logic on CLK_SYS_I;
// the three master clock inputs are asynchronous pins and run well below half of CLK_SYS_I.
//
// Function
// - Frame divider codes give 128/256/384/512, reset 128.
// - Master bit clock is 64 times frame clock.
// - Source codes main, receiver ref, recovered; 11 reserved.
// - Bit 0 picks slip or block start trigger.
// - Register validity bit drives transmitted validity flag.
// - Transmitter register 1 fields at documented bit positions.
`timescale 1ns/1ps
`default_nettype none

module pbclk_regs
(
	// Clock and reset
	input  wire logic                     CLK_SYS_I,
	input  wire logic                     RST_I,
	// Register port
	input  wire logic [7:0]               REG_ADDR_I,
	input  wire logic [7:0]               REG_WDATA_I,
	input  wire logic                     REG_WR_I,
	input  wire logic                     REG_RD_I,
	output var  logic [7:0]               REG_RDATA_O,
	// Master clock candidates
	input  wire logic                     MAIN_REF_CLOCK_I,
	input  wire logic                     RECEIVER_REFERENCE_CLOCK_IN_I,
	input  wire logic                     RECOVERED_RECEIVER_CLOCK_I,
	// Port B clocks
	input  wire logic                     PORT_B_MASTER_SELECT_I,
	output var  logic                     PORT_B_BIT_CLOCK_O,
	output var  logic                     PORT_B_BIT_CLOCK_OE_O,
	output var  logic                     PORT_B_FRAME_CLOCK_O,
	output var  logic                     PORT_B_FRAME_CLOCK_OE_O,
	// Transmitter
	input  wire logic                     VALIDITY_SOURCE_SELECT_I,
	input  wire logic                     TX_STREAM_VALIDITY_I,
	input  wire logic                     TX_DATA_SLIP_I,
	input  wire logic                     TX_BLOCK_START_I,
	output var  logic                     TX_VALIDITY_O,
	output var  logic                     TRANSMITTER_SLIP_FLAG_SET_O,
	output var  pbclk_pkg::pbclk_tx_cfg_s TX_CONFIG_O
);

	// ==========================================================================
	// Register file
	pbclk_pkg::pbclk_port_b_cfg_s pb_cfg;
	pbclk_pkg::pbclk_port_b_cfg_s next_pb_cfg;
	pbclk_pkg::pbclk_tx_cfg_s     next_tx_cfg;
	logic [7:0]                   next_rdata;
	logic                         wr_pb;
	logic                         wr_tx;

	assign wr_pb = REG_WR_I && (REG_ADDR_I == pbclk_pkg::PBCLK_OFS_PORT_B_CONTROL_2);
	assign wr_tx = REG_WR_I && (REG_ADDR_I == pbclk_pkg::PBCLK_OFS_TRANSMITTER_CTRL_1);

	always_comb
	begin
		next_pb_cfg = pb_cfg;
		next_tx_cfg = TX_CONFIG_O;
		next_rdata  = REG_RDATA_O;
		if (wr_pb)
		begin
			next_pb_cfg.master_source        = REG_WDATA_I[pbclk_pkg::PBCLK_POS_MASTER_SOURCE +: 2];
			next_pb_cfg.port_b_frame_divider = REG_WDATA_I[pbclk_pkg::PBCLK_POS_FRAME_DIVIDER +: 2];
		end
		if (wr_tx)
		begin
			next_tx_cfg.transmitter_clock_source   = REG_WDATA_I[pbclk_pkg::PBCLK_POS_TX_CLOCK_SOURCE];
			next_tx_cfg.transmitter_clock_divider  = REG_WDATA_I[pbclk_pkg::PBCLK_POS_TX_DIVIDER +: 2];
			next_tx_cfg.transmitter_input_source   = REG_WDATA_I[pbclk_pkg::PBCLK_POS_INPUT_SOURCE +: 2];
			next_tx_cfg.block_start_pin_direction  = REG_WDATA_I[pbclk_pkg::PBCLK_POS_BLOCK_START_DIR];
			next_tx_cfg.validity                   = REG_WDATA_I[pbclk_pkg::PBCLK_POS_VALIDITY];
			next_tx_cfg.slip_or_block_start_select = REG_WDATA_I[pbclk_pkg::PBCLK_POS_SLIP_SELECT];
		end
		if (REG_RD_I)
		begin
			if (REG_ADDR_I == pbclk_pkg::PBCLK_OFS_PORT_B_CONTROL_2)
			begin
				next_rdata = {pbclk_pkg::PBCLK_PORT_B_CONTROL_2_UPPER, pb_cfg};
			end
			else if (REG_ADDR_I == pbclk_pkg::PBCLK_OFS_TRANSMITTER_CTRL_1)
			begin
				next_rdata = TX_CONFIG_O;
			end
			else
			begin
				next_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			pb_cfg      <= pbclk_pkg::PBCLK_RST_PORT_B_CONTROL_2;
			TX_CONFIG_O <= pbclk_pkg::PBCLK_RST_TRANSMITTER_CTRL_1;
			REG_RDATA_O <= 8'h00;
		end
		else
		begin
			pb_cfg      <= next_pb_cfg;
			TX_CONFIG_O <= next_tx_cfg;
			REG_RDATA_O <= next_rdata;
		end
	end

	a_upper_nibble_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(REG_RD_I && REG_ADDR_I == pbclk_pkg::PBCLK_OFS_PORT_B_CONTROL_2) |=> (REG_RDATA_O[7:4] == 4'h0))
		else $error("Upper bits of port B control register 2 read nonzero.");

	a_tx_readback_layout: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_tx ##1 (REG_RD_I && !REG_WR_I && REG_ADDR_I == pbclk_pkg::PBCLK_OFS_TRANSMITTER_CTRL_1))
		|=> (REG_RDATA_O == $past(REG_WDATA_I, 2)) && (TX_CONFIG_O.validity == REG_RDATA_O[1]))
		else $error("Transmitter control register 1 readback differs from the written value.");

	// ==========================================================================
	// Master clock synchronisers and edge detect
	logic [pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS-1:0] mclk_pin;
	logic [pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS-1:0] mclk_meta;
	logic [pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS-1:0] mclk_sync;
	logic [pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS-1:0] mclk_last;
	logic [pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS-1:0] mclk_rise;
	logic                                          tick;

	assign mclk_pin = {RECOVERED_RECEIVER_CLOCK_I, RECEIVER_REFERENCE_CLOCK_IN_I, MAIN_REF_CLOCK_I};

	genvar g;
	generate
		for (g = 0; g < pbclk_pkg::PBCLK_NUM_MASTER_CLOCKS; g++)
		begin : g_sync
			always_ff @(posedge CLK_SYS_I)
			begin
				if (RST_I)
				begin
					mclk_meta[g] <= 1'b0;
					mclk_sync[g] <= 1'b0;
					mclk_last[g] <= 1'b0;
				end
				else
				begin
					mclk_meta[g] <= mclk_pin[g];
					mclk_sync[g] <= mclk_meta[g];
					mclk_last[g] <= mclk_sync[g];
				end
			end
			assign mclk_rise[g] = mclk_sync[g] & ~mclk_last[g];
		end
	endgenerate

	// The reserved source code selects nothing, so the divider stands still.
	always_comb
	begin
		unique case (pb_cfg.master_source)
			pbclk_pkg::PBCLK_SRC_MAIN_REF:     tick = mclk_rise[0];
			pbclk_pkg::PBCLK_SRC_RECEIVER_REF: tick = mclk_rise[1];
			pbclk_pkg::PBCLK_SRC_RECOVERED:    tick = mclk_rise[2];
			pbclk_pkg::PBCLK_SRC_RESERVED:     tick = 1'b0;
		endcase
	end

	a_reserved_source_idle: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(pb_cfg.master_source == pbclk_pkg::PBCLK_SRC_RESERVED) |-> !tick ##1 $stable(PORT_B_BIT_CLOCK_O))
		else $error("Reserved master clock source produced clock activity.");

	// ==========================================================================
	// Port B clock generation and pin drive
	logic next_oe;
	logic oe;

	// Outside master mode the far end owns both clock pins, so the drivers are released.
	assign next_oe = PORT_B_MASTER_SELECT_I;

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			oe <= 1'b0;
		end
		else
		begin
			oe <= next_oe;
		end
	end

	assign PORT_B_BIT_CLOCK_OE_O   = oe;
	assign PORT_B_FRAME_CLOCK_OE_O = oe;

	pbclk_div u_div
	(
		.clk_i       (CLK_SYS_I),
		.rst_i       (RST_I),
		.en_i        (PORT_B_MASTER_SELECT_I),
		.restart_i   (wr_pb),
		.tick_i      (tick),
		.div_i       (pb_cfg.port_b_frame_divider),
		.bit_clk_o   (PORT_B_BIT_CLOCK_O),
		.frame_clk_o (PORT_B_FRAME_CLOCK_O)
	);

	// ==========================================================================
	// Transmitter validity and slip trigger
	logic next_validity;
	logic next_slip_set;

	always_comb
	begin
		next_validity = VALIDITY_SOURCE_SELECT_I ? TX_CONFIG_O.validity : TX_STREAM_VALIDITY_I;
		next_slip_set = TX_CONFIG_O.slip_or_block_start_select ? TX_BLOCK_START_I : TX_DATA_SLIP_I;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			TX_VALIDITY_O               <= 1'b0;
			TRANSMITTER_SLIP_FLAG_SET_O <= 1'b0;
		end
		else
		begin
			TX_VALIDITY_O               <= next_validity;
			TRANSMITTER_SLIP_FLAG_SET_O <= next_slip_set;
		end
	end

	a_validity_from_reg: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(VALIDITY_SOURCE_SELECT_I && $stable(TX_CONFIG_O)) |=> (TX_VALIDITY_O == $past(TX_CONFIG_O.validity)))
		else $error("Transmitted validity flag does not follow the register bit.");

	a_slip_by_block_start: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(TX_CONFIG_O.slip_or_block_start_select && TX_BLOCK_START_I) |=> TRANSMITTER_SLIP_FLAG_SET_O)
		else $error("Block start did not set the slip flag trigger.");

	a_slip_ignores_slip: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(!TX_CONFIG_O.slip_or_block_start_select && !TX_DATA_SLIP_I) |=> !TRANSMITTER_SLIP_FLAG_SET_O)
		else $error("Slip flag trigger set without a data slip.");

endmodule

`default_nettype wire

// ---- tb/pbclk_far_end.sv ----
// Far-end audio processor model on port B.
// Assumes the clock pins and their output enables come straight from the design.
`timescale 1ns/1ps
`default_nettype none

module pbclk_far_end
(
	// Device side of the pins
	input  wire logic bit_clk_i,
	input  wire logic bit_oe_i,
	input  wire logic frame_clk_i,
	input  wire logic frame_oe_i,
	// Resolved wires and measurement
	output var  logic bit_wire_o,
	output var  logic frame_wire_o,
	output var  int   bits_per_frame_o
);
	logic slave_bit   = 1'b0;
	logic slave_frame = 1'b0;
	int   half        = 0;
	int   cnt         = 0;
	int   mark        = 0;

	// In slave mode the far end makes both clocks itself.
	always #40 slave_bit = ~slave_bit;
	always @(negedge slave_bit)
	begin
		half++;
		if (half == 32)
		begin
			half = 0;
			slave_frame = ~slave_frame;
		end
	end

	assign bit_wire_o   = bit_oe_i ? bit_clk_i : slave_bit;
	assign frame_wire_o = frame_oe_i ? frame_clk_i : slave_frame;

	// Counts bit clock periods per frame clock period, as a receiving processor would.
	// The running count and the mark each have one writer, so the two processes never race.
	always @(posedge bit_wire_o) cnt++;
	always @(posedge frame_wire_o)
	begin
		bits_per_frame_o = cnt - mark;
		mark = cnt;
	end
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the port B clock and transmitter control registers.
// Assumes the design under core/ and the far-end model in tb/pbclk_far_end.sv.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic       clk    = 1'b0;
	logic       rst    = 1'b1;
	logic [7:0] addr   = 8'h00;
	logic [7:0] wdata  = 8'h00;
	logic       wr     = 1'b0;
	logic       rd     = 1'b0;
	logic       mref   = 1'b0;
	logic       rref   = 1'b0;
	logic       rec    = 1'b0;
	logic       msel   = 1'b0;
	logic       vsel   = 1'b0;
	logic       svalid = 1'b0;
	logic       slip   = 1'b0;
	logic       bstart = 1'b0;
	logic [1:0] src    = 2'h0;
	logic [7:0] rdata;
	logic       bclk;
	logic       boe;
	logic       fclk;
	logic       foe;
	logic       valid_o;
	logic       slip_set;
	logic       bw;
	logic       fw;
	logic       selc;
	pbclk_pkg::pbclk_tx_cfg_s txcfg;
	int         failures  = 0;
	int         cmp_count = 0;
	int         mcnt      = 0;
	int         bcnt      = 0;
	int         bpf;
	int         m0;

	// ==========================================================================
	// Clocks and counters
	always #5 clk = ~clk;
	always #30 mref = ~mref;
	always #40 rref = ~rref;
	always #50 rec = ~rec;
	assign selc = (src == 2'h0) ? mref : (src == 2'h1) ? rref : rec;
	always @(posedge selc) mcnt++;
	always @(posedge bclk) bcnt++;

	// ==========================================================================
	// Design and far end
	pbclk_regs u_dut
	(
		.CLK_SYS_I                     (clk),
		.RST_I                         (rst),
		.REG_ADDR_I                    (addr),
		.REG_WDATA_I                   (wdata),
		.REG_WR_I                      (wr),
		.REG_RD_I                      (rd),
		.REG_RDATA_O                   (rdata),
		.MAIN_REF_CLOCK_I              (mref),
		.RECEIVER_REFERENCE_CLOCK_IN_I (rref),
		.RECOVERED_RECEIVER_CLOCK_I    (rec),
		.PORT_B_MASTER_SELECT_I        (msel),
		.PORT_B_BIT_CLOCK_O            (bclk),
		.PORT_B_BIT_CLOCK_OE_O         (boe),
		.PORT_B_FRAME_CLOCK_O          (fclk),
		.PORT_B_FRAME_CLOCK_OE_O       (foe),
		.VALIDITY_SOURCE_SELECT_I      (vsel),
		.TX_STREAM_VALIDITY_I          (svalid),
		.TX_DATA_SLIP_I                (slip),
		.TX_BLOCK_START_I              (bstart),
		.TX_VALIDITY_O                 (valid_o),
		.TRANSMITTER_SLIP_FLAG_SET_O   (slip_set),
		.TX_CONFIG_O                   (txcfg)
	);

	pbclk_far_end u_far
	(
		.bit_clk_i        (bclk),
		.bit_oe_i         (boe),
		.frame_clk_i      (fclk),
		.frame_oe_i       (foe),
		.bit_wire_o       (bw),
		.frame_wire_o     (fw),
		.bits_per_frame_o (bpf)
	);

	// ==========================================================================
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		step(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		step(1);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	// Writes a register and reads it back in the very next cycle.
	task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		step(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	// Measures one full frame: master clocks per frame and bit clocks per frame.
	task automatic frame(input logic [1:0] s, input logic [1:0] c);
		src = s;
		wr_reg(8'h06, {4'h0, s, c});
		@(posedge fclk);
		m0 = mcnt;
		@(posedge fclk);
		#1;
		chk(16'(mcnt - m0), 16'h0080 * ({14'h0, c} + 16'h0001));
		chk(16'(bpf), 16'h0040);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================================
	// Tests
	initial
	begin
		step(16);
		rst = 1'b0;
		msel = 1'b1;
		rd_chk(8'h06, 8'h00);
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h05, 8'h00);
		chk(16'(txcfg), 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			wr_rd_chk(8'h07, 8'h01 << i, 8'h01 << i);
			chk(16'(txcfg), 16'h0001 << i);
		end
		wr_rd_chk(8'h06, 8'hff, 8'h0f);
		m0 = bcnt;
		step(200);
		chk(16'(bcnt - m0), 16'h0000);
		$display("test readback done");
		for (int c = 0; c < 4; c++)
			frame(2'h0, 2'(c));
		frame(2'h1, 2'h0);
		frame(2'h2, 2'h1);
		$display("test divider done");
		msel = 1'b0;
		step(2);
		chk({12'h000, boe, foe, bclk, fclk}, 16'h0000);
		// The first frame edge may come from the pin hand-over, so a full slave frame is measured after it.
		repeat (3) @(posedge fw);
		step(1);
		chk(16'(bpf), 16'h0040);
		$display("test slave done");
		vsel = 1'b1;
		wr_reg(8'h07, 8'h02);
		step(1);
		chk({15'h0, valid_o}, 16'h0001);
		chk({15'h0, txcfg.validity}, 16'h0001);
		vsel = 1'b0;
		step(2);
		chk({15'h0, valid_o}, 16'h0000);
		svalid = 1'b1;
		step(1);
		chk({15'h0, valid_o}, 16'h0001);
		svalid = 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			wr_reg(8'h07, {7'h00, 1'(s)});
			for (int e = 0; e < 2; e++)
			begin
				slip = (e == 0);
				bstart = (e == 1);
				step(1);
				chk({15'h0, slip_set}, {15'h0, 1'(s == e)});
				slip = 1'b0;
				bstart = 1'b0;
				step(1);
			end
		end
		$display("test transmitter done");
		complete_run();
	end

	initial
	begin
		// The tests need about 200 us; twice that means the run has hung.
		#400000;
		failures++;
		complete_run();
	end
endmodule

`default_nettype wire
